/* fld_map.svh */
`ifndef FLD_MAP_SVH
`define FLD_MAP_SVH
// Functional notes
// - Each channel has four indicator pins; mode bits 3:1 and an enable pick them.
// - Mode 000 puts the 4-bit coarse magnitude on pins 3 to 0.
// - In mode 000 the coarse code appears two clocks after its sample.
// - Mode 001: 3-bit coarse code on pins 3 to 1, overrange on pin 0.
// - Modes 010/011: 2-bit code on pins 3:2, pin 1 overrange or coarse-upper, pin 0 fine-lower.
// - Modes 001, 010, 011 put the code and coarse-upper six clocks after the sample, overrange and fine-lower two.
// - Mode 100 and 101 drive four threshold or gain-hint flags.
// - The 4-bit code steps through the nine magnitude bands below full scale.
// - The 3-bit code merges the top two 4-bit bands into code 111.
// - The 2-bit code marks four bands split at -14.5, -7 and -3.25 dB.
// - Every indication except overrange uses the sample magnitude and ignores its sign.
// - The overrange flag is the full 14-bit overflow indication.
// - Software sets thresholds; the upper flags stay low below and rise above, fine-lower the reverse.
// - The coarse magnitude comes from the first pipeline stage code.
// - Overrange appears two clocks after the offending sample.
// - In modes 100 and 101 coarse-upper rises two clocks after crossing and holds at least two clocks.
// - Fine flags compare full magnitude with separate 13-bit thresholds.
// - Gain-drop follows coarse-upper; gain-raise waits a 16-bit dwell below fine-lower.

// ****************************************************************
// Register addresses
// ****************************************************************
`define FLD_ADDR_W          13
`define FLD_ADDR_CTRL       13'h104
`define FLD_ADDR_CUT        13'h105
`define FLD_ADDR_FUT_LO     13'h106
`define FLD_ADDR_FUT_HI     13'h107
`define FLD_ADDR_FLT_LO     13'h108
`define FLD_ADDR_FLT_HI     13'h109
`define FLD_ADDR_DWELL_LO   13'h10A
`define FLD_ADDR_DWELL_HI   13'h10B
`define FLD_ADDR_STATUS     13'h10C

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define FLD_CTRL_EN_BIT     0
`define FLD_CTRL_MODE_HI    3
`define FLD_CTRL_MODE_LO    1
`define FLD_CTRL_RST        8'h00
`define FLD_CUT_RST         3'h7
`define FLD_FINE_RST        13'h0000
`define FLD_DWELL_RST       16'h0001
`define FLD_THR_HI_W        5

// ****************************************************************
// Magnitude codes and timing
// ****************************************************************
`define FLD_CODE_MAX        4'h8
`define FLD_CODE3_MAX       3'h7
`define FLD_BAND_1          4'h2
`define FLD_BAND_2          4'h4
`define FLD_BAND_3          4'h6
`define FLD_SLOW_DLY        4
`define FLD_FIFO_DEPTH      32
`define FLD_FIFO_AW         5
`define FLD_DWELL_ONE       16'h0001
`endif

/* fld_pkg.sv */
`include "fld_map.svh"
package fld_pkg;

    typedef enum logic [2:0]
    {
        FLD_MODE_MAG4     = 3'h0,
        FLD_MODE_MAG3_OVR = 3'h1,
        FLD_MODE_MAG2_OVR = 3'h2,
        FLD_MODE_MAG2_CUT = 3'h3,
        FLD_MODE_FLAGS    = 3'h4,
        FLD_MODE_GAIN     = 3'h5
    } fld_mode_e;

    typedef logic [3:0]  fld_code_t;
    typedef logic [13:0] fld_data_t;
    typedef logic [12:0] fld_thr_t;
    typedef logic [15:0] fld_dwell_t;
    typedef logic [29:0] fld_word_t;

endpackage : fld_pkg

/* fld_fifo.sv */
module fld_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 32,
    parameter int AW    = 5
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             in_ready,
    // Drain side
    output      logic             out_valid,
    output      logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    // Fill level
    output      logic [AW:0]      level
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    // ************************************************************
    // Handshake
    // ************************************************************
    assign push  = in_valid && in_ready;
    assign pop   = (count_r != '0) && (!out_valid || out_ready);
    assign level = count_r;

    always_comb
    begin
        count_nxt = count_r;
        if (push && !pop)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r  <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            count_r  <= count_nxt;
            in_ready <= (count_nxt != (AW+1)'(DEPTH));
        end
    end

    // ************************************************************
    // Storage and pointers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // ************************************************************
    // Output register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data  <= mem_r[rd_ptr_r];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end

endmodule : fld_fifo

/* fld_dwell.sv */
`include "fld_map.svh"
module fld_dwell
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Comparison and setting
    input  wire logic              below,
    input  wire fld_pkg::fld_dwell_t dwell,
    // Hint
    output      logic              raise
);
    import fld_pkg::*;

    fld_dwell_t  count_r;
    fld_dwell_t  target;

    // ************************************************************
    // Dwell count
    // ************************************************************
    assign target = (dwell == '0) ? `FLD_DWELL_ONE : dwell;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r <= '0;
            raise   <= 1'b0;
        end
        else
        begin
            if (!below)
            begin
                count_r <= '0;
            end
            else if (count_r != '1)
            begin
                count_r <= count_r + 1'b1;
            end
            raise <= below && ({1'b0, count_r} + 17'h1 >= {1'b0, target});
        end
    end

endmodule : fld_dwell

/* fld_top.sv */
`include "fld_map.svh"
module fld_top
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Register access
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [12:0]          reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output      logic [7:0]           reg_rdata,
    // First stage codes, signed
    input  wire logic signed [4:0]    stage1_code [2],
    // Converted samples, pipeline end
    input  wire logic                 conv_valid,
    input  wire fld_pkg::fld_data_t   conv_data [2],
    input  wire logic                 conv_ovr [2],
    output      logic                 conv_ready,
    // Buffered sample stream
    output      logic                 data_out_valid,
    output      fld_pkg::fld_word_t   data_out,
    input  wire logic                 data_out_ready,
    // Indicator pins
    output      logic [3:0]           early_level_outputs [2]
);
    import fld_pkg::*;

    logic [7:0]      ctrl_r;
    logic [2:0]      cut_thr_r;
    fld_thr_t        fut_thr_r;
    fld_thr_t        flt_thr_r;
    fld_dwell_t      dwell_r;
    logic            enable;
    logic [2:0]      mode;
    logic [5:0]      fifo_level;
    logic [7:0]      rd_mux;

    // ************************************************************
    // Control registers
    // ************************************************************
    assign enable = ctrl_r[`FLD_CTRL_EN_BIT];
    assign mode   = ctrl_r[`FLD_CTRL_MODE_HI:`FLD_CTRL_MODE_LO];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r    <= `FLD_CTRL_RST;
            cut_thr_r <= `FLD_CUT_RST;
            fut_thr_r <= `FLD_FINE_RST;
            flt_thr_r <= `FLD_FINE_RST;
            dwell_r   <= `FLD_DWELL_RST;
        end
        else if (reg_wr_en)
        begin
            unique case (reg_addr)
                `FLD_ADDR_CTRL:     ctrl_r <= reg_wdata;
                `FLD_ADDR_CUT:      cut_thr_r <= reg_wdata[2:0];
                `FLD_ADDR_FUT_LO:   fut_thr_r[7:0] <= reg_wdata;
                `FLD_ADDR_FUT_HI:   fut_thr_r[12:8] <= reg_wdata[`FLD_THR_HI_W-1:0];
                `FLD_ADDR_FLT_LO:   flt_thr_r[7:0] <= reg_wdata;
                `FLD_ADDR_FLT_HI:   flt_thr_r[12:8] <= reg_wdata[`FLD_THR_HI_W-1:0];
                `FLD_ADDR_DWELL_LO: dwell_r[7:0] <= reg_wdata;
                `FLD_ADDR_DWELL_HI: dwell_r[15:8] <= reg_wdata;
                default:            ;
            endcase
        end
    end

    // ************************************************************
    // Register read
    // ************************************************************
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `FLD_ADDR_CTRL:     rd_mux = ctrl_r;
            `FLD_ADDR_CUT:      rd_mux = {5'h00, cut_thr_r};
            `FLD_ADDR_FUT_LO:   rd_mux = fut_thr_r[7:0];
            `FLD_ADDR_FUT_HI:   rd_mux = {3'h0, fut_thr_r[12:8]};
            `FLD_ADDR_FLT_LO:   rd_mux = flt_thr_r[7:0];
            `FLD_ADDR_FLT_HI:   rd_mux = {3'h0, flt_thr_r[12:8]};
            `FLD_ADDR_DWELL_LO: rd_mux = dwell_r[7:0];
            `FLD_ADDR_DWELL_HI: rd_mux = dwell_r[15:8];
            `FLD_ADDR_STATUS:   rd_mux = {2'h0, fifo_level};
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata <= rd_mux;
        end
    end

    // ************************************************************
    // Sample buffer
    // ************************************************************
    fld_fifo #(
        .WIDTH (30),
        .DEPTH (`FLD_FIFO_DEPTH),
        .AW    (`FLD_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (conv_valid),
        .in_data   ({conv_ovr[1], conv_data[1], conv_ovr[0], conv_data[0]}),
        .in_ready  (conv_ready),
        .out_valid (data_out_valid),
        .out_data  (data_out),
        .out_ready (data_out_ready),
        .level     (fifo_level)
    );

    // ************************************************************
    // Per-channel indicator logic
    // ************************************************************
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        fld_code_t        coarse_abs_r;
        fld_code_t        coarse_abs;
        logic [4:0]       stage_mag;
        logic [3:0][3:0]  code_dly_r;
        logic [3:0]       cut_dly_r;
        logic             cut_raw;
        logic             cut_hold_r;
        logic             cut;
        fld_code_t        slow_code;
        logic [2:0]       code3;
        logic [1:0]       code2;
        fld_data_t        mag;
        logic             fut_r;
        logic             flt_r;
        logic             ovr_r;
        logic             flt_raw;
        logic             raise;
        logic [3:0]       pins;

        // Coarse magnitude from first stage code, sign dropped
        assign stage_mag  = 5'(stage1_code[g][4] ? -stage1_code[g] : stage1_code[g]);
        assign coarse_abs = (stage_mag > {1'b0, `FLD_CODE_MAX}) ? `FLD_CODE_MAX
                                                                : stage_mag[3:0];

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                coarse_abs_r <= '0;
                code_dly_r   <= '0;
                cut_dly_r    <= '0;
                cut_hold_r   <= 1'b0;
            end
            else
            begin
                coarse_abs_r <= coarse_abs;
                code_dly_r   <= {code_dly_r[2:0], coarse_abs_r};
                cut_dly_r    <= {cut_dly_r[2:0], cut};
                cut_hold_r   <= cut_raw;
            end
        end

        // Coarse-upper compare with two-cycle hold
        assign cut_raw = (coarse_abs_r >= {1'b0, cut_thr_r});
        assign cut     = cut_raw || cut_hold_r;

        // Reduced codes
        assign slow_code = code_dly_r[`FLD_SLOW_DLY-1];
        assign code3 = (slow_code >= `FLD_CODE_MAX) ? `FLD_CODE3_MAX : slow_code[2:0];

        always_comb
        begin
            if (slow_code < `FLD_BAND_1)
            begin
                code2 = 2'h0;
            end
            else if (slow_code < `FLD_BAND_2)
            begin
                code2 = 2'h1;
            end
            else if (slow_code < `FLD_BAND_3)
            begin
                code2 = 2'h2;
            end
            else
            begin
                code2 = 2'h3;
            end
        end

        // Full-resolution magnitude and flags
        assign mag     = conv_data[g][13] ? 14'(-conv_data[g]) : conv_data[g];
        assign flt_raw = (mag < {1'b0, flt_thr_r});

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                fut_r <= 1'b0;
                flt_r <= 1'b0;
                ovr_r <= 1'b0;
            end
            else
            begin
                fut_r <= (mag > {1'b0, fut_thr_r});
                flt_r <= flt_raw;
                ovr_r <= conv_ovr[g];
            end
        end

        fld_dwell u_dwell (
            .clk   (clk),
            .rst_b (rst_b),
            .below (flt_raw),
            .dwell (dwell_r),
            .raise (raise)
        );

        // Pin multiplexer
        always_comb
        begin
            pins = 4'h0;
            if (enable)
            begin
                unique case (mode)
                    FLD_MODE_MAG4:     pins = coarse_abs_r;
                    FLD_MODE_MAG3_OVR: pins = {code3, ovr_r};
                    FLD_MODE_MAG2_OVR: pins = {code2, ovr_r, flt_r};
                    FLD_MODE_MAG2_CUT: pins = {code2, cut_dly_r[`FLD_SLOW_DLY-1],
                        flt_r};
                    FLD_MODE_FLAGS:    pins = {ovr_r, cut, fut_r, flt_r};
                    FLD_MODE_GAIN:     pins = {ovr_r, fut_r, raise, cut};
                    default:           pins = 4'h0;
                endcase
            end
        end

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                early_level_outputs[g] <= 4'h0;
            end
            else
            begin
                early_level_outputs[g] <= pins;
            end
        end
    end

endmodule : fld_top

/* fld_top_properties.sv */
module fld_checker
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // Register access
    input wire logic                reg_wr_en,
    input wire logic                reg_rd_en,
    input wire logic [12:0]         reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    // Samples
    input wire logic signed [4:0]   stage1_code [2],
    input wire logic                conv_ovr [2],
    // Stream and pins
    input wire logic                data_out_valid,
    input wire fld_pkg::fld_word_t  data_out,
    input wire logic                data_out_ready,
    input wire logic [3:0]          early_level_outputs [2]
);
    import fld_pkg::*;
    logic [7:0] ctrl_r;
    logic [2:0] cut_r;
    logic [3:0] age_r;
    logic       live_w;
    logic [2:0] mode_w;

    function automatic logic [3:0] mag(input logic signed [4:0] c);
        int a;
        a = (c < 0) ? -int'(c) : int'(c);
        return (a > 8) ? 4'h8 : 4'(a);
    endfunction : mag

    function automatic logic [2:0] mag3(input logic signed [4:0] c);
        return (mag(c) > 4'h7) ? 3'h7 : 3'(mag(c));
    endfunction : mag3

    function automatic logic [1:0] mag2(input logic signed [4:0] c);
        return (mag(c) < 4'h2) ? 2'h0 : (mag(c) < 4'h4) ? 2'h1 : (mag(c) < 4'h6) ? 2'h2 : 2'h3;
    endfunction : mag2

    // Shadow of written setup
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r <= 8'h00;
            cut_r  <= 3'h7;
        end
        else if (reg_wr_en && reg_addr == 13'h104)
            ctrl_r <= reg_wdata;
        else if (reg_wr_en && reg_addr == 13'h105)
            cut_r <= reg_wdata[2:0];
    end

    // Cycles since last setup change
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            age_r <= 4'h0;
        else if (reg_wr_en && (reg_addr == 13'h104 || reg_addr == 13'h105))
            age_r <= 4'h0;
        else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
    end

    assign mode_w = ctrl_r[3:1];
    assign live_w = ctrl_r[0] && (age_r > 4'h7);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_mag4_latency:
    assert property (live_w && mode_w == FLD_MODE_MAG4 |->
        early_level_outputs[0] == mag($past(stage1_code[0], 2))
        && early_level_outputs[1] == mag($past(stage1_code[1], 2)))
        else $error("four-bit code wrong");
    a_mag3_latency:
    assert property (live_w && mode_w == FLD_MODE_MAG3_OVR |->
        early_level_outputs[0][3:1] == mag3($past(stage1_code[0], 6)))
        else $error("three-bit code wrong");
    a_mag2_latency:
    assert property (live_w && (mode_w == FLD_MODE_MAG2_OVR || mode_w == FLD_MODE_MAG2_CUT) |->
        early_level_outputs[1][3:2] == mag2($past(stage1_code[1], 6)))
        else $error("two-bit code wrong");
    a_off_low:
    assert property (age_r > 4'h7 && (!ctrl_r[0] || mode_w > 3'h5) |->
        early_level_outputs[0] == 4'h0 && early_level_outputs[1] == 4'h0)
        else $error("pins not low when off");
    a_ovr_flag:
    assert property (live_w && mode_w == FLD_MODE_FLAGS |->
        early_level_outputs[0][3] == $past(conv_ovr[0], 2))
        else $error("overrange pin wrong");
    a_cut_hit:
    assert property (live_w && mode_w == FLD_MODE_FLAGS
        && mag($past(stage1_code[0], 2)) >= {1'b0, cut_r} |-> early_level_outputs[0][2])
        else $error("coarse upper missed");
    a_cut_hold:
    assert property (live_w && mode_w == FLD_MODE_FLAGS && $rose(early_level_outputs[0][2])
        |=> early_level_outputs[0][2])
        else $error("coarse upper too short");
    a_rd_unmapped:
    assert property (reg_rd_en && (reg_addr < 13'h104 || reg_addr > 13'h10C)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_out_hold:
    assert property (data_out_valid && !data_out_ready |=> data_out_valid && $stable(data_out))
        else $error("stream word dropped");

    c_mag4: cover property (live_w && mode_w == FLD_MODE_MAG4 && early_level_outputs[0] == 4'h8);
    c_cut_rise: cover property ($rose(early_level_outputs[0][2]));
    c_stall: cover property (data_out_valid && !data_out_ready);
endmodule : fld_checker

bind fld_top fld_checker u_chk (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .stage1_code(stage1_code), .conv_ovr(conv_ovr), .data_out_valid(data_out_valid),
    .data_out(data_out), .data_out_ready(data_out_ready),
    .early_level_outputs(early_level_outputs));

/* fld_agc_sink.sv */
module fld_agc_sink
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // Slow answer on request
    input  wire logic               stall,
    // Buffered stream
    input  wire logic               data_out_valid,
    input  wire fld_pkg::fld_word_t data_out,
    output      logic               data_out_ready
);
    import fld_pkg::*;
    fld_word_t got_q [$];

    assign data_out_ready = rst_b && !stall;

    // Word taken on a ready edge
    always @(posedge clk)
    begin
        if (data_out_valid && data_out_ready)
            got_q.push_back(data_out);
    end
endmodule : fld_agc_sink

/* fld_top_tb.sv */
`include "fld_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module fld_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fld_pkg::*;
    logic              clk;
    logic              rst_b;
    logic              reg_wr_en;
    logic              reg_rd_en;
    logic [12:0]       reg_addr;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic signed [4:0] stage1_code [2];
    logic              conv_valid;
    fld_data_t         conv_data [2];
    logic              conv_ovr [2];
    logic              conv_ready;
    logic              data_out_valid;
    fld_word_t         data_out;
    logic              data_out_ready;
    logic [3:0]        early_level_outputs [2];
    logic              stall;
    int                fail_count;
    int                tests_run;

    fld_top u_dut (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stage1_code(stage1_code), .conv_valid(conv_valid), .conv_data(conv_data),
        .conv_ovr(conv_ovr), .conv_ready(conv_ready), .data_out_valid(data_out_valid),
        .data_out(data_out), .data_out_ready(data_out_ready),
        .early_level_outputs(early_level_outputs));
    fld_agc_sink u_sink (.clk(clk), .rst_b(rst_b), .stall(stall),
        .data_out_valid(data_out_valid), .data_out(data_out), .data_out_ready(data_out_ready));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********************
    // Drivers
    // ********************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick(1);
        reg_rd_en = 1'b0;
        tick(1);
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd

    task automatic drv(input int v, input int m, input logic o);
        stage1_code[0] = 5'(v);
        stage1_code[1] = 5'(-v);
        conv_data[0] = 14'(m);
        conv_data[1] = 14'(-m);
        conv_ovr[0] = o;
        conv_ovr[1] = o;
    endtask : drv

    task automatic pins(input logic [3:0] e);
        `CHK("pins_a", e, early_level_outputs[0])
        `CHK("pins_b", e, early_level_outputs[1])
    endtask : pins

    task automatic lat(input int n, input logic [3:0] idle, input logic [3:0] hit, input int v);
        drv(0, 0, 1'b0);
        tick(8);
        drv(v, 0, 1'b0);
        tick(1);
        drv(0, 0, 1'b0);
        tick(n - 2);
        pins(idle);
        tick(1);
        pins(hit);
    endtask : lat

    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        pins(4'h0);
        rd(13'h104, 8'h00);
        rd(13'h105, 8'h07);
        rd(13'h106, 8'h00);
        rd(13'h10A, 8'h01);
        wr(13'h0FF, 8'hFF);
        rd(13'h0FF, 8'h00);
        rd(13'h10D, 8'h00);
        wr(13'h107, 8'hFF);
        rd(13'h107, 8'h1F);
        wr(13'h107, 8'h00);
        $display("done registers");
    endtask : t_regs

    task automatic t_mag4();
        int e;
        wr(13'h104, 8'h01);
        for (int v = -15; v < 16; v++)
        begin
            drv(v, 0, 1'b0);
            tick(3);
            e = (v < 0) ? -v : v;
            pins(4'((e > 8) ? 8 : e));
        end
        lat(2, 4'h0, 4'h7, -7);
        $display("done four-bit code");
    endtask : t_mag4

    task automatic t_sub();
        logic [3:0] e;
        wr(13'h105, 8'h03);
        for (int m = 1; m < 4; m++)
        begin
            wr(13'h104, 8'(m * 2 + 1));
            for (int v = 0; v < 10; v++)
            begin
                drv(-v, 0, 1'b1);
                tick(8);
                e = (m == 1) ? {3'((v > 7) ? 7 : v), 1'b1} :
                    {2'((v < 2) ? 0 : (v < 4) ? 1 : (v < 6) ? 2 : 3), (m == 2) || (v > 2), 1'b0};
                pins(e);
            end
        end
        wr(13'h104, 8'h03);
        lat(6, 4'h0, 4'hA, 5);
        $display("done reduced codes");
    endtask : t_sub

    task automatic t_flags();
        int         tv [7] = '{0, -4, 0, 3, 0, 0, 0};
        int         tm [7] = '{120, -120, 30, -75, 100, 50, 49};
        logic [3:0] te [7] = '{4'h2, 4'hE, 4'h1, 4'hC, 4'h0, 4'h0, 4'h1};
        wr(13'h106, 8'h64);
        wr(13'h108, 8'h32);
        wr(13'h10A, 8'h05);
        wr(13'h104, 8'h09);
        for (int i = 0; i < 7; i++)
        begin
            drv(tv[i], tm[i], te[i][3]);
            tick(8);
            pins(te[i]);
        end
        wr(13'h104, 8'h0B);
        drv(4, 120, 1'b1);
        tick(8);
        pins(4'hD);
        drv(0, 30, 1'b0);
        tick(4);
        pins(4'h0);
        tick(8);
        pins(4'h2);
        $display("done flags");
    endtask : t_flags

    task automatic t_off();
        logic [7:0] tc [3] = '{8'h0D, 8'h0F, 8'h08};
        drv(9, 120, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            wr(13'h104, tc[i]);
            tick(8);
            pins(4'h0);
        end
        $display("done off modes");
    endtask : t_off

    task automatic t_fifo();
        int   n;
        logic rdy;
        n = 0;
        stall = 1'b1;
        conv_valid = 1'b1;
        conv_ovr[0] = 1'b1;
        conv_ovr[1] = 1'b0;
        repeat (40)
        begin
            conv_data[0] = 14'(n);
            conv_data[1] = 14'(n + 100);
            rdy = conv_ready;
            tick(1);
            n += int'(rdy);
        end
        conv_valid = 1'b0;
        `CHK("accepted", `FLD_FIFO_DEPTH + 1, n)
        rd(13'h10C, 8'h20);
        for (int i = 0; i < 200 && u_sink.got_q.size() < n; i++)
        begin
            stall = i[0];
            tick(1);
        end
        stall = 1'b0;
        `CHK("drained", n, u_sink.got_q.size())
        for (int i = 0; i < n && i < u_sink.got_q.size(); i++)
            `CHK("word", {1'b0, 14'(i + 100), 1'b1, 14'(i)}, u_sink.got_q[i])
        rd(13'h10C, 8'h00);
        $display("done buffer");
    endtask : t_fifo

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #50000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        fail_count = 0;
        tests_run = 0;
        rst_b = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 13'h000;
        reg_wdata = 8'h00;
        conv_valid = 1'b0;
        stall = 1'b0;
        drv(0, 0, 1'b0);
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        tick(1);
        t_regs();
        t_mag4();
        t_sub();
        t_flags();
        t_off();
        t_fifo();
        tally_and_finish();
    end
endmodule : fld_top_tb
